// [hw/entry_stage_pkg.sv]
// Constants for the address table entry write staging block
package entry_stage_pkg;
   // Register indices; byte address is index shifted by ADDR_SHIFT
   localparam logic [15:0] IDX_COMMAND   = 16'h1800;
   localparam logic [15:0] IDX_ADDR_LOW  = 16'h1801;
   localparam logic [15:0] IDX_ADDR_HIGH = 16'h1802;
   localparam int          ADDR_SHIFT    = 2;
   // Reset values
   localparam logic [31:0] RST_ADDR_LOW  = 32'h0000_0000;
   localparam logic [31:0] RST_ADDR_HIGH = 32'h0000_0000;
   // Command register field
   localparam int          CMD_MAKE_BIT  = 2;
   // Second staging word fields
   localparam int          F_VALID       = 26;
   localparam int          F_AGE1_OVR    = 25;
   localparam int          F_STATIC      = 24;
   localparam int          F_AGE0_FILT   = 23;
   localparam int          F_PRIO_EN     = 22;
   localparam int          F_PRIO_LSB    = 19;
   localparam int          F_PORT_LSB    = 16;
   localparam int          F_PORT_MULTI  = 18;
   localparam logic [31:0] HIGH_WMASK    = 32'h07FF_FFFF;
   // Destination port codes
   localparam logic [2:0]  PORT_0        = 3'h0;
   localparam logic [2:0]  PORT_1        = 3'h1;
   localparam logic [2:0]  PORT_2        = 3'h2;
   localparam logic [2:0]  PORT_RSVD     = 3'h3;
   localparam logic [2:0]  PORT_01       = 3'h4;
   localparam logic [2:0]  PORT_02       = 3'h5;
   localparam logic [2:0]  PORT_12       = 3'h6;
   localparam logic [2:0]  PORT_ALL      = 3'h7;
   // Commit handshake states, Gray ordered
   typedef enum logic [0:0] {
      CMT_IDLE = 1'b0,
      CMT_BUSY = 1'b1
   } commit_state_t;
endpackage

// [hw/entry_attr_if.sv]
// Carrier between the staging bank and its attribute decoder
`timescale 1ns/1ns
`default_nettype none
interface entry_attr_if;
   logic [31:0] attrs;       // Committed second staging word
   logic        da_top_prio; // Global destination priority enable
   logic        is_static;
   logic        ages;
   logic [1:0]  age_timer;
   logic        override;
   logic        filter;
   logic        prio_use;
   logic [2:0]  prio;
   logic [2:0]  port_mask;
   logic        port_rsvd;
   modport src (output attrs, output da_top_prio,
                input is_static, input ages, input age_timer,
                input override, input filter, input prio_use,
                input prio, input port_mask, input port_rsvd);
   modport dec (input attrs, input da_top_prio,
                output is_static, output ages, output age_timer,
                output override, output filter, output prio_use,
                output prio, output port_mask, output port_rsvd);
endinterface
`default_nettype wire

// [hw/entry_attr_decode.sv]
// Decoder of entry attribute bits into table-side meanings
`timescale 1ns/1ns
`default_nettype none
module entry_attr_decode
   import entry_stage_pkg::*;
#(
   parameter int NUM_PORTS = 3
) (
   // Attribute carrier
   entry_attr_if.dec ea
);
   initial begin
      if (NUM_PORTS != 3) begin
         $error("entry_attr_decode serves exactly three ports");
      end
   end

   logic [2:0] code;
   assign code = ea.attrs[F_PORT_LSB +: 3];

   // Static and aging meanings share bits 25 and 23
   always_comb begin
      ea.is_static = ea.attrs[F_STATIC];
      ea.ages      = ~ea.attrs[F_STATIC];
      ea.age_timer = ea.attrs[F_STATIC] ? 2'h0 :
                     {ea.attrs[F_AGE1_OVR], ea.attrs[F_AGE0_FILT]};
      ea.override  = ea.attrs[F_STATIC] & ea.attrs[F_AGE1_OVR];
      ea.filter    = ea.attrs[F_STATIC] & ea.attrs[F_AGE0_FILT];
   end

   // Priority applies only with both the entry and global enables
   always_comb begin
      ea.prio_use = ea.attrs[F_PRIO_EN] & ea.da_top_prio;
      ea.prio     = ea.prio_use ? ea.attrs[F_PRIO_LSB +: 3] : 3'h0;
   end

   // Port code to mask; bit 18 selects the multi-port half
   always_comb begin
      ea.port_rsvd = 1'b0;
      case (code)
         PORT_0:    ea.port_mask = 3'h1;
         PORT_1:    ea.port_mask = 3'h2;
         PORT_2:    ea.port_mask = 3'h4;
         PORT_01:   ea.port_mask = 3'h3;
         PORT_02:   ea.port_mask = 3'h5;
         PORT_12:   ea.port_mask = 3'h6;
         PORT_ALL:  ea.port_mask = 3'h7;
         default: begin
            // Reserved code forwards nowhere rather than guessing
            ea.port_mask = 3'h0;
            ea.port_rsvd = 1'b1;
         end
      endcase
   end
endmodule // entry_attr_decode
`default_nettype wire

// [hw/entry_write_stage.sv]
// APB staging registers and make-entry commit for the address table
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - First word holds the first 32 address bits, reset zero, bit 0 multicast
// - Second word bits 15:0 hold the last 16 address bits, reset zero
// - Bit 26 marks entry valid; cleared it invalidates a matching entry
// - Static bit 24 stops aging removal and learning changes
// - Non-static entries age out after 5 to 10 idle minutes
// - Non-static: bits 25 and 23 form the two-bit aging timer
// - Static with bit 25: forward regardless of port state except disabled
// - Static with bit 23: discard packets to this address
// - Bit 22 enables the priority field; clear means ignored
// - Priority 21:19 used only with entry and global enables both set
// - Bits 18:16 encode single ports, port pairs or all ports
// - Make command copies both words into the table
module entry_write_stage
   import entry_stage_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Global setting from the ingress configuration
   input  wire logic              da_top_prio,
   // Table commit handshake
   output logic                   commit_req,
   input  wire logic              commit_ack,
   // Committed entry towards the table
   output logic      [47:0]       entry_mac,
   output logic                   entry_valid,
   output logic                   entry_static,
   output logic                   entry_ages,
   output logic      [1:0]        entry_age_timer,
   output logic                   entry_override,
   output logic                   entry_filter,
   output logic                   entry_prio_use,
   output logic      [2:0]        entry_prio,
   output logic      [2:0]        entry_port_mask,
   output logic                   entry_port_rsvd
);
   // Refuse bus widths that cannot reach the top register index;
   // a narrower compare would alias the staging words silently
   initial begin
      if (ADDR_W < 15 || ADDR_W > 32) begin
         $error("entry_write_stage needs ADDR_W from 15 to 32");
      end
      if (ADDR_SHIFT != 2) begin
         $error("entry_write_stage expects one word per four bytes");
      end
      if (HIGH_WMASK[31:27] != 5'h00) begin
         $error("entry_write_stage must mask bits 31 to 27");
      end
   end

   // Carrier and decoder; the decoder sees the snapshot and the live global enable
   entry_attr_if ea ();

   entry_attr_decode #(
      .NUM_PORTS (3)
   ) u_decode (
      .ea (ea)
   );

   // Word index from byte address; low two bits are ignored,
   // so an unaligned address reaches the word that holds it
   logic [ADDR_W-1:0] word_idx;
   logic              hit_cmd;
   logic              hit_low;
   logic              hit_high;
   logic              hit_any;
   logic              setup;
   logic              wr_en;
   assign word_idx = paddr >> ADDR_SHIFT;
   assign hit_cmd  = (word_idx == ADDR_W'(IDX_COMMAND));
   assign hit_low  = (word_idx == ADDR_W'(IDX_ADDR_LOW));
   assign hit_high = (word_idx == ADDR_W'(IDX_ADDR_HIGH));
   assign hit_any  = hit_cmd | hit_low | hit_high;
   assign setup    = psel & ~penable;
   assign wr_en    = psel & penable & pwrite;

   // Staging words and commit state
   logic [31:0]   addr_low;
   logic [31:0]   addr_high;
   logic [31:0]   next_addr_low;
   logic [31:0]   next_addr_high;
   commit_state_t state;
   commit_state_t next_state;
   // Only bit 2 of a command write starts anything; others are ignored
   logic          make_wr;
   assign make_wr = wr_en & hit_cmd & pwdata[CMD_MAKE_BIT];

   // Next values of staging words; writes are allowed while busy
   // because the commit works from its own snapshot
   // Reserved bits are dropped here so no later reader sees them
   always_comb begin
      next_addr_low  = addr_low;
      next_addr_high = addr_high;
      if (wr_en && hit_low) begin
         next_addr_low = pwdata;
      end
      if (wr_en && hit_high) begin
         next_addr_high = pwdata & HIGH_WMASK;
      end
   end

   // Staging words clear to zero on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_low  <= RST_ADDR_LOW;
         addr_high <= RST_ADDR_HIGH;
      end else begin
         addr_low  <= next_addr_low;
         addr_high <= next_addr_high;
      end
   end

   // Commit handshake: make raises the request, the table's ack
   // drops it; a new make in the ack cycle wins over the clear,
   // so a late reprogram is never lost
   always_comb begin
      next_state = state;
      case (state)
         CMT_IDLE: begin
            if (make_wr) begin
               next_state = CMT_BUSY;
            end
         end
         CMT_BUSY: begin
            if (commit_ack && !make_wr) begin
               next_state = CMT_IDLE;
            end
         end
         default: next_state = CMT_IDLE;
      endcase
   end

   // Commit state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= CMT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Pending flag as software sees it at the command word;
   // it stays high until the table acknowledges the commit
   logic pending;
   assign pending = (state == CMT_BUSY);

   // Snapshot of the staged entry taken at the make command;
   // a staging write must finish before the make that uses it
   logic [47:0] snap_mac;
   logic [31:0] snap_attrs;
   logic [47:0] next_snap_mac;
   logic [31:0] next_snap_attrs;
   logic        take_snap;
   assign take_snap = make_wr;

   always_comb begin
      next_snap_mac   = snap_mac;
      next_snap_attrs = snap_attrs;
      if (take_snap) begin
         next_snap_mac   = {addr_high[15:0], addr_low};
         next_snap_attrs = addr_high;
      end
   end

   // Snapshot register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_mac   <= 48'h0000_0000_0000;
         snap_attrs <= 32'h0000_0000;
      end else begin
         snap_mac   <= next_snap_mac;
         snap_attrs <= next_snap_attrs;
      end
   end

   // The decoder sees the snapshot and the live global enable
   assign ea.attrs       = snap_attrs;
   assign ea.da_top_prio = da_top_prio;

   // Next values of the entry outputs; decoded meaning follows the
   // snapshot, so reprogramming a staging word never disturbs a
   // commit that the table has not yet acknowledged; the global
   // priority enable is the one live input and acts a cycle later
   logic        next_commit_req;
   logic [47:0] next_entry_mac;
   logic        next_entry_valid;
   logic        next_entry_static;
   logic        next_entry_ages;
   logic [1:0]  next_entry_age_timer;
   logic        next_entry_override;
   logic        next_entry_filter;
   logic        next_entry_prio_use;
   logic [2:0]  next_entry_prio;
   logic [2:0]  next_entry_port_mask;
   logic        next_entry_port_rsvd;
   always_comb begin
      next_commit_req      = (next_state == CMT_BUSY);
      next_entry_mac       = snap_mac;
      next_entry_valid     = snap_attrs[F_VALID];
      next_entry_static    = ea.is_static;
      next_entry_ages      = ea.ages;
      next_entry_age_timer = ea.age_timer;
      next_entry_override  = ea.override;
      next_entry_filter    = ea.filter;
      next_entry_prio_use  = ea.prio_use;
      next_entry_prio      = ea.prio;
      next_entry_port_mask = ea.port_mask;
      next_entry_port_rsvd = ea.port_rsvd;
   end

   // Entry outputs come straight from flops towards the table
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         commit_req      <= 1'b0;
         entry_mac       <= 48'h0000_0000_0000;
         entry_valid     <= 1'b0;
         entry_static    <= 1'b0;
         entry_ages      <= 1'b0;
         entry_age_timer <= 2'h0;
         entry_override  <= 1'b0;
         entry_filter    <= 1'b0;
         entry_prio_use  <= 1'b0;
         entry_prio      <= 3'h0;
         entry_port_mask <= 3'h0;
         entry_port_rsvd <= 1'b0;
      end else begin
         commit_req      <= next_commit_req;
         entry_mac       <= next_entry_mac;
         entry_valid     <= next_entry_valid;
         entry_static    <= next_entry_static;
         entry_ages      <= next_entry_ages;
         entry_age_timer <= next_entry_age_timer;
         entry_override  <= next_entry_override;
         entry_filter    <= next_entry_filter;
         entry_prio_use  <= next_entry_prio_use;
         entry_prio      <= next_entry_prio;
         entry_port_mask <= next_entry_port_mask;
         entry_port_rsvd <= next_entry_port_rsvd;
      end
   end

   // Word seen at the current address; unmapped reads give zero
   // Reserved bits are masked again so nothing stale can leak
   logic [31:0] read_word;
   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_cmd) begin
         read_word[CMD_MAKE_BIT] = pending;
      end else if (hit_low) begin
         read_word = addr_low;
      end else if (hit_high) begin
         read_word = addr_high & HIGH_WMASK;
      end
   end

   // Read data and error prepared in the setup cycle so that
   // the access phase finishes with no wait state; the price is
   // that a read returns the word as it stood at setup
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        next_pready;
   always_comb begin
      next_prdata  = prdata;
      next_pslverr = pslverr;
      next_pready  = 1'b1;
      if (setup) begin
         next_pslverr = ~hit_any;
         next_prdata  = read_word;
      end
   end

   // Bus response registers; ready stays high once out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
         pready  <= next_pready;
      end
   end
endmodule // entry_write_stage
`default_nettype wire

// [testbench/entry_write_checker.sv]
// Assertion checker for the entry write staging block
`timescale 1ns/1ns
`default_nettype none
module entry_write_checker
   import entry_stage_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   // Clock, reset and bus
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   // Commit and entry
   input wire logic              da_top_prio,
   input wire logic              commit_req,
   input wire logic              commit_ack,
   input wire logic              entry_static,
   input wire logic              entry_ages,
   input wire logic [1:0]        entry_age_timer,
   input wire logic              entry_override,
   input wire logic              entry_filter,
   input wire logic              entry_prio_use,
   input wire logic [2:0]        entry_prio,
   input wire logic [2:0]        entry_port_mask,
   input wire logic              entry_port_rsvd
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   localparam logic [15:0] A_CMD = IDX_COMMAND << ADDR_SHIFT;
   localparam logic [15:0] A_HI  = IDX_ADDR_HIGH << ADDR_SHIFT;
   // Completed access and make request decode
   wire logic acc  = psel && penable && pready;
   wire logic make = acc && pwrite && paddr == A_CMD && pwdata[CMD_MAKE_BIT];

   ready_up_a: assert property ($past(presetn) |-> pready)
      else $error("pready low after reset");
   make_req_a: assert property (make |=> commit_req)
      else $error("make did not raise commit_req");
   req_hold_a: assert property (commit_req && !commit_ack |=> commit_req)
      else $error("commit_req dropped without ack");
   req_drop_a: assert property (commit_req && commit_ack && !make |=> !commit_req)
      else $error("commit_req held after ack");
   resv_zero_a: assert property (acc && !pwrite && paddr == A_HI |-> prdata[31:27] == 5'h00)
      else $error("reserved bits read nonzero");
   static_age_a: assert property (entry_static |-> !entry_ages && entry_age_timer == 2'h0)
      else $error("static entry ages");
   ovr_filt_a: assert property (entry_override || entry_filter |-> entry_static)
      else $error("override or filter without static");
   prio_gate_a: assert property (entry_prio_use |-> $past(da_top_prio))
      else $error("priority used without global enable");
   prio_off_a: assert property (!entry_prio_use |-> entry_prio == 3'h0)
      else $error("priority nonzero while unused");
   port_rsvd_a: assert property (entry_port_rsvd |-> entry_port_mask == 3'h0)
      else $error("reserved port code gave ports");
   // Main scenarios
   make_c: cover property (make);
   ack_c: cover property (commit_req && commit_ack);
   rsvd_c: cover property (entry_port_rsvd);
   age_c: cover property (entry_ages && entry_age_timer == 2'h3);
endmodule // entry_write_checker
bind entry_write_stage entry_write_checker #(.ADDR_W(ADDR_W)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .da_top_prio(da_top_prio), .commit_req(commit_req),
   .commit_ack(commit_ack), .entry_static(entry_static),
   .entry_ages(entry_ages), .entry_age_timer(entry_age_timer),
   .entry_override(entry_override), .entry_filter(entry_filter),
   .entry_prio_use(entry_prio_use), .entry_prio(entry_prio),
   .entry_port_mask(entry_port_mask), .entry_port_rsvd(entry_port_rsvd));
`default_nettype wire

// [testbench/address_table_entry_write_staging_bench.sv]
// Self-checking bench for the entry write staging block
`timescale 1ns/1ns
`default_nettype none
module address_table_entry_write_staging_bench
   import entry_stage_pkg::*;
;
   localparam logic [15:0] A_CMD = IDX_COMMAND << ADDR_SHIFT;
   localparam logic [15:0] A_LO  = IDX_ADDR_LOW << ADDR_SHIFT;
   localparam logic [15:0] A_HI  = IDX_ADDR_HIGH << ADDR_SHIFT;
   logic        pclk, presetn, psel, penable, pwrite, da_top_prio;
   logic        commit_ack, pready, pslverr, commit_req, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [47:0] entry_mac;
   logic [2:0]  entry_prio, entry_port_mask;
   logic [1:0]  entry_age_timer;
   logic        entry_valid, entry_static, entry_ages, entry_override;
   logic        entry_filter, entry_prio_use, entry_port_rsvd;
   int          miscompares, n_tests;

   entry_write_stage #(.ADDR_W(16)) u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .da_top_prio(da_top_prio),
      .commit_req(commit_req), .commit_ack(commit_ack),
      .entry_mac(entry_mac), .entry_valid(entry_valid),
      .entry_static(entry_static), .entry_ages(entry_ages),
      .entry_age_timer(entry_age_timer), .entry_override(entry_override),
      .entry_filter(entry_filter), .entry_prio_use(entry_prio_use),
      .entry_prio(entry_prio), .entry_port_mask(entry_port_mask),
      .entry_port_rsvd(entry_port_rsvd));

   // 10 MHz clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input string nm, input logic [47:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         $display("FAIL pready expected 1 seen %b", pready);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Stage, make, check the committed entry, then acknowledge
   task automatic run_entry(input logic [31:0] w0, w1, input logic dp);
      logic [2:0] c;
      logic [2:0] m;
      logic       s;
      logic       pu;
      c = w1[18:16];
      s = w1[24];
      pu = w1[22] & dp;
      // Pairs are all ports but one: 4 drops 2, 5 drops 1, 6 drops 0
      m = c[2] ? ~(3'h4 >> c[1:0]) : (c == 3'h3 ? 3'h0 : 3'h1 << c[1:0]);
      da_top_prio <= dp;
      apb(1'b1, A_LO, w0);
      apb(1'b1, A_HI, w1);
      apb(1'b1, A_CMD, 32'h0000_0004);
      repeat (3) @(negedge pclk);
      chk("commit_req", 48'h1, {47'h0, commit_req});
      chk("mac", {w1[15:0], w0}, entry_mac);
      chk("valid", {47'h0, w1[26]}, {47'h0, entry_valid});
      chk("static", {47'h0, s}, {47'h0, entry_static});
      chk("ages", {47'h0, ~s}, {47'h0, entry_ages});
      chk("timer", {46'h0, s ? 2'h0 : {w1[25], w1[23]}}, {46'h0, entry_age_timer});
      chk("override", {47'h0, s & w1[25]}, {47'h0, entry_override});
      chk("filter", {47'h0, s & w1[23]}, {47'h0, entry_filter});
      chk("prio_use", {47'h0, pu}, {47'h0, entry_prio_use});
      chk("prio", {45'h0, pu ? w1[21:19] : 3'h0}, {45'h0, entry_prio});
      chk("ports", {45'h0, m}, {45'h0, entry_port_mask});
      chk("port_rsvd", {47'h0, c == 3'h3}, {47'h0, entry_port_rsvd});
      apb(1'b0, A_CMD, 32'h0);
      chk("pending", 48'h4, {16'h0, rd});
      @(posedge pclk);
      commit_ack <= 1'b1;
      @(posedge pclk);
      commit_ack <= 1'b0;
      apb(1'b0, A_CMD, 32'h0);
      chk("done", 48'h0, {16'h0, rd});
   endtask

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog far beyond the few hundred cycles the tests need
   initial begin
      #500000;
      miscompares++;
      $display("FAIL watchdog expected finish seen timeout");
      final_report;
   end

   initial begin
      logic [2:0] k;
      {presetn, psel, penable, pwrite, da_top_prio, commit_ack} = 6'h00;
      paddr = 16'h0000;
      pwdata = 32'h0;
      miscompares = 0;
      n_tests = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, A_LO, 32'h0);
      chk("low reset", 48'h0, {16'h0, rd});
      apb(1'b0, A_HI, 32'h0);
      chk("high reset", 48'h0, {16'h0, rd});
      $display("test reset values done");
      apb(1'b1, A_LO, 32'hA5C3_5A3C);
      apb(1'b0, A_LO, 32'h0);
      chk("low rw", 48'hA5C3_5A3C, {16'h0, rd});
      chk("mapped err", 48'h0, {47'h0, err});
      apb(1'b1, A_HI, 32'hFFFF_FFFF);
      apb(1'b0, A_HI, 32'h0);
      chk("high rw", 48'h07FF_FFFF, {16'h0, rd});
      apb(1'b0, 16'h6010, 32'h0);
      chk("unmapped err", 48'h1, {47'h0, err});
      chk("unmapped data", 48'h0, {16'h0, rd});
      apb(1'b1, A_CMD, 32'hFFFF_FFFB);
      chk("no req", 48'h0, {47'h0, commit_req});
      apb(1'b0, A_CMD, 32'h0);
      chk("no make", 48'h0, {16'h0, rd});
      $display("test register access done");
      for (int i = 0; i < 8; i++) begin
         k = 3'(i);
         run_entry(32'h5A00_0001 ^ 32'(i << 8), {5'h1F, ~k[0], k[1], k[0],
                   ~k[1], k[2], k ^ 3'h5, k, 16'hC3A0 ^ 16'(i)}, k[1]);
      end
      run_entry(32'h0123_4567, 32'h0680_1234, 1'b0);
      run_entry(32'h89AB_CDEF, 32'h056F_BEEF, 1'b1);
      $display("test entry commits done");
      final_report;
   end
endmodule // address_table_entry_write_staging_bench
`default_nettype wire
